// ---- logic/gei_params.svh ----
// register offsets, field positions and reset values of the interrupt and port block
// assumes byte addressing on an apb bus with one 32-bit word per register
`ifndef GEI_PARAMS_SVH
`define GEI_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GEI_OFS_PORT_DATA    8'h00
`define GEI_OFS_EDGE_SELECT  8'h04
`define GEI_OFS_LINE_DIR     8'h08
`define GEI_OFS_ENABLE_A     8'h0C
`define GEI_OFS_ENABLE_B     8'h10
`define GEI_OFS_PENDING_A    8'h14
`define GEI_OFS_PENDING_B    8'h18
`define GEI_OFS_IN_SERVICE_A 8'h1C
`define GEI_OFS_IN_SERVICE_B 8'h20
`define GEI_OFS_MASK_A       8'h24
`define GEI_OFS_MASK_B       8'h28
`define GEI_OFS_VECTOR       8'h2C
`define GEI_OFS_CONTROL      8'h30

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GEI_VEC_SVC_BIT      3
`define GEI_VEC_BASE_LSB     4
`define GEI_CTRL_POLL_BIT    0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GEI_RST_BYTE         8'h00
`define GEI_RST_CHANNELS     16'h0000

`endif

// ---- logic/gei_pkg.sv ----
// types shared by the interrupt and port block
// assumes nothing beyond a systemverilog compiler
package gei_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef logic [15:0] gei_chan_t;
  typedef logic [7:0]  gei_byte_t;

  // acknowledge sequencing
  typedef enum logic [1:0] {
    GEI_ACK_IDLE,
    GEI_ACK_ANSWER,
    GEI_ACK_RELEASE
  } gei_ack_e;

endpackage

// ---- logic/gei_edge_detect.sv ----
// per-line synchroniser and selectable transition detector for the port
// assumes pin levels synchronous to sys_clk but still passes them through two flops
`timescale 1ns/1ps
`include "gei_params.svh"

module gei_edge_detect
  import gei_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] line_in,
  input  wire logic [W-1:0] edge_sel,
  output logic      [W-1:0] level,
  output logic      [W-1:0] event_hit
);

  if (W < 1) begin : g_chk
    $error("gei_edge_detect needs at least one line");
  end

  // ----------------------------------------------------------------------
  // per-line detector
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_line
    logic meta;
    logic prev_x;
    logic x;

    // xor of edge bit and level: a chosen edge always becomes a fall of x
    assign x = level[i] ^ edge_sel[i];
    assign event_hit[i] = prev_x & ~x;

    // two flops, then one for the detector history
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        meta     <= 1'b0;
        level[i] <= 1'b0;
        prev_x   <= 1'b0;
      end else if (ce) begin
        meta     <= line_in[i];
        level[i] <= meta;
        prev_x   <= x;
      end
    end

    a_single_event: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && event_hit[i]) |=> !event_hit[i])
      else $error("edge event lasted more than one cycle");
  end

endmodule // gei_edge_detect

// ---- logic/gei_prio_encode.sv ----
// highest-index-wins priority encoder over the interrupt channels
// assumes a one-hot or sparse request vector, purely combinational
`timescale 1ns/1ps
`include "gei_params.svh"

module gei_prio_encode
  import gei_pkg::*;
#(
  parameter int N = 16
) (
  input  wire logic [N-1:0]         req,
  output logic                      any,
  output logic      [$clog2(N)-1:0] idx
);

  if (N < 2) begin : g_chk
    $error("gei_prio_encode needs at least two channels");
  end

  // later hits overwrite earlier ones, so the top channel wins
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[$clog2(N)-1:0];
      end
    end
  end

endmodule // gei_prio_encode

// ---- logic/gei_top.sv ----
// interrupt nesting logic with end-of-interrupt modes and an eight-line interrupt port
// assumes an apb master on the register side and a host raising ack_cycle_n
//
// Notes on behaviour
// - service bit one selects software end mode
// - polled operation ignores end-of-interrupt modes
// - passing a vector clears its pending bit
// - automatic mode holds in-service bits at zero
// - automatic mode lets any later interrupt request
// - software mode sets in-service bit on vector
// - in-service blocks equal and lower channels
// - blocked channels still record pending interrupts
// - in-service writes clear zeros, keep ones
// - eight lines, each input or output
// - per-line selectable edge, per-line enable
// - outputs drive data bit, inputs float
// - reads give data bit or pin level
// - edge bit zero falls, one rises
// - detector xors edge bit with level
// - direction zero input, one push-pull output
// - each port line has its own vector
// - pending writes clear zeros, keep ones
// - masked channels pend but do not request
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "gei_params.svh"

module gei_top
  import gei_pkg::*;
#(
  parameter int LINES = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // port pins
  input  wire logic [LINES-1:0] port_in,
  output logic      [LINES-1:0] port_out,
  output logic      [LINES-1:0] port_oe,
  // internal sources, one-cycle pulses
  input  wire logic [7:0]       src_event,
  // host interrupt side
  input  wire logic             ack_cycle_n,
  output logic                  irq_n,
  output logic                  vector_valid,
  output logic      [7:0]       vector_num,
  output logic                  ack_pass
);

  if (LINES != 8) begin : g_chk
    $error("gei_top channel map serves exactly eight port lines");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  gei_byte_t port_data;
  gei_byte_t edge_select;
  gei_byte_t line_direction;
  gei_byte_t vector_reg;
  logic      polled;
  gei_chan_t enable;
  gei_chan_t pending;
  gei_chan_t in_service;
  gei_chan_t mask;
  gei_ack_e  ack_st;

  gei_byte_t level;
  gei_byte_t port_hit;
  gei_chan_t chan_hit;
  gei_chan_t blocked;
  gei_chan_t req;
  logic      any_req;
  logic [3:0] win_idx;
  logic      soft_mode;
  logic      ack_take;
  logic      wr_en;
  logic      access;

  // ----------------------------------------------------------------------
  // port edge detection
  // ----------------------------------------------------------------------
  gei_edge_detect #(.W(LINES)) u_edge (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .line_in   (port_in),
    .edge_sel  (edge_select),
    .level     (level),
    .event_hit (port_hit)
  );

  // channel map, top bit highest priority; each line owns one channel
  assign chan_hit = {port_hit[7], port_hit[6], src_event[7:2],
                     port_hit[5], port_hit[4], src_event[1:0], port_hit[3:0]};

  // ----------------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------------
  assign soft_mode = vector_reg[`GEI_VEC_SVC_BIT];

  // a set in-service bit holds back its own channel and every lower one
  for (genvar c = 0; c < 16; c++) begin : g_block
    assign blocked[c] = |in_service[15:c];
  end

  // enable gates pending and requests; mask gates requests only, so pending still records
  assign req = pending & enable & mask
             & ~(blocked & {16{~polled}});

  gei_prio_encode #(.N(16)) u_prio (
    .req (req),
    .any (any_req),
    .idx (win_idx)
  );

  // vector passed in the answer cycle of a vectored acknowledge
  assign ack_take = ce && (ack_st == GEI_ACK_ANSWER) && any_req;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  assign access = psel & penable & pready;
  assign wr_en  = ce & access & pwrite;

  // zero-wait answer: pready rises in the first access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable & ~pready;
    end
  end

  // read data and error captured at the setup edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        unique case (paddr)
          `GEI_OFS_PORT_DATA:    prdata[7:0] <= (port_data & line_direction)
                                              | (level & ~line_direction);
          `GEI_OFS_EDGE_SELECT:  prdata[7:0] <= edge_select;
          `GEI_OFS_LINE_DIR:     prdata[7:0] <= line_direction;
          `GEI_OFS_ENABLE_A:     prdata[7:0] <= enable[15:8];
          `GEI_OFS_ENABLE_B:     prdata[7:0] <= enable[7:0];
          `GEI_OFS_PENDING_A:    prdata[7:0] <= pending[15:8];
          `GEI_OFS_PENDING_B:    prdata[7:0] <= pending[7:0];
          `GEI_OFS_IN_SERVICE_A: prdata[7:0] <= in_service[15:8];
          `GEI_OFS_IN_SERVICE_B: prdata[7:0] <= in_service[7:0];
          `GEI_OFS_MASK_A:       prdata[7:0] <= mask[15:8];
          `GEI_OFS_MASK_B:       prdata[7:0] <= mask[7:0];
          `GEI_OFS_VECTOR:       prdata[7:0] <= vector_reg;
          `GEI_OFS_CONTROL:      prdata[0]   <= polled;
          default:               pslverr     <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // plain control registers
  // ----------------------------------------------------------------------
  // port configuration; reset leaves every line an input
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_data      <= `GEI_RST_BYTE;
      edge_select    <= `GEI_RST_BYTE;
      line_direction <= `GEI_RST_BYTE;
    end else if (wr_en) begin
      if (paddr == `GEI_OFS_PORT_DATA)   port_data      <= pwdata[7:0];
      if (paddr == `GEI_OFS_EDGE_SELECT) edge_select    <= pwdata[7:0];
      if (paddr == `GEI_OFS_LINE_DIR)    line_direction <= pwdata[7:0];
    end
  end

  // channel enable, mask, vector base and scheme select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable     <= `GEI_RST_CHANNELS;
      mask       <= `GEI_RST_CHANNELS;
      vector_reg <= `GEI_RST_BYTE;
      polled     <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `GEI_OFS_ENABLE_A) enable[15:8] <= pwdata[7:0];
      if (paddr == `GEI_OFS_ENABLE_B) enable[7:0]  <= pwdata[7:0];
      if (paddr == `GEI_OFS_MASK_A)   mask[15:8]   <= pwdata[7:0];
      if (paddr == `GEI_OFS_MASK_B)   mask[7:0]    <= pwdata[7:0];
      if (paddr == `GEI_OFS_VECTOR)   vector_reg   <= pwdata[7:0];
      if (paddr == `GEI_OFS_CONTROL)  polled       <= pwdata[`GEI_CTRL_POLL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // port pins
  // ----------------------------------------------------------------------
  // output lines follow the data bit; input lines are released
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_out <= `GEI_RST_BYTE;
      port_oe  <= `GEI_RST_BYTE;
    end else if (ce) begin
      port_out <= port_data;
      port_oe  <= line_direction;
    end
  end

  // ----------------------------------------------------------------------
  // pending bits
  // ----------------------------------------------------------------------
  // order matters: clears first, a fresh event last so it is never lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending <= `GEI_RST_CHANNELS;
    end else if (ce) begin
      gei_chan_t next_pending;
      next_pending = pending;
      if (wr_en && paddr == `GEI_OFS_PENDING_A)
        next_pending[15:8] = next_pending[15:8] & pwdata[7:0];
      if (wr_en && paddr == `GEI_OFS_PENDING_B)
        next_pending[7:0] = next_pending[7:0] & pwdata[7:0];
      if (wr_en && paddr == `GEI_OFS_ENABLE_A)
        next_pending[15:8] = next_pending[15:8] & pwdata[7:0];
      if (wr_en && paddr == `GEI_OFS_ENABLE_B)
        next_pending[7:0] = next_pending[7:0] & pwdata[7:0];
      if (ack_take)
        next_pending[win_idx] = 1'b0;
      next_pending = next_pending | (chan_hit & enable);
      pending <= next_pending;
    end
  end

  // ----------------------------------------------------------------------
  // in-service bits
  // ----------------------------------------------------------------------
  // only hardware sets them, and only in software end mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_service <= `GEI_RST_CHANNELS;
    end else if (ce) begin
      gei_chan_t next_in_service;
      next_in_service = in_service;
      if (wr_en && paddr == `GEI_OFS_IN_SERVICE_A)
        next_in_service[15:8] = next_in_service[15:8] & pwdata[7:0];
      if (wr_en && paddr == `GEI_OFS_IN_SERVICE_B)
        next_in_service[7:0] = next_in_service[7:0] & pwdata[7:0];
      if (ack_take && soft_mode)
        next_in_service[win_idx] = 1'b1;
      if (!soft_mode)
        next_in_service = `GEI_RST_CHANNELS;
      in_service <= next_in_service;
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge sequencing
  // ----------------------------------------------------------------------
  // one answer per acknowledge, then wait for the host to release it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_st <= GEI_ACK_IDLE;
    end else if (ce) begin
      unique case (ack_st)
        GEI_ACK_IDLE:    if (!ack_cycle_n && !polled) ack_st <= GEI_ACK_ANSWER;
        GEI_ACK_ANSWER:  ack_st <= GEI_ACK_RELEASE;
        GEI_ACK_RELEASE: if (ack_cycle_n) ack_st <= GEI_ACK_IDLE;
      endcase
    end
  end

  // vector or pass-on indication held until the acknowledge ends
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vector_valid <= 1'b0;
      ack_pass     <= 1'b0;
      vector_num   <= `GEI_RST_BYTE;
    end else if (ce) begin
      if (ack_st == GEI_ACK_ANSWER) begin
        vector_valid <= any_req;
        ack_pass     <= ~any_req;
        vector_num   <= {vector_reg[7:`GEI_VEC_BASE_LSB], win_idx};
      end else if (ack_cycle_n) begin
        vector_valid <= 1'b0;
        ack_pass     <= 1'b0;
      end
    end
  end

  // request line lags the gating by one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else if (ce) begin
      irq_n <= ~any_req;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ack_begin;
    ce && ack_st == GEI_ACK_IDLE && !ack_cycle_n && !polled;
  endsequence

  sequence s_ack_answer;
    ce ##1 (vector_valid || ack_pass);
  endsequence

  a_ack_answers: assert property (s_ack_begin |=> s_ack_answer)
    else $error("acknowledge got no answer two cycles later");

  a_ack_clears_pend: assert property (
    (ack_take && !chan_hit[win_idx]) |=> !pending[$past(win_idx)])
    else $error("pending bit survived its vector");

  a_soft_sets_isr: assert property (
    (ack_take && soft_mode) |=> in_service[$past(win_idx)])
    else $error("in-service bit not set in software end mode");

  a_auto_isr_zero: assert property ((ce && !soft_mode) |=> in_service == 16'h0000)
    else $error("in-service bit set in automatic mode");

  a_vector_above_isr: assert property (
    (ack_take && !polled) |-> !(|(in_service >> win_idx)))
    else $error("vector passed below an in-service channel");

  a_isr_never_set: assert property (
    (wr_en && !ack_take) |=> (in_service & ~$past(in_service)) == 16'h0000)
    else $error("software write set an in-service bit");

  a_pend_keep_ones: assert property (
    (wr_en && paddr == `GEI_OFS_PENDING_B && pwdata[7:0] == 8'hFF && !ack_take)
    |=> ($past(pending[7:0]) & ~pending[7:0]) == 8'h00)
    else $error("writing ones changed pending bits");

  a_dir_to_pins: assert property (
    (wr_en && paddr == `GEI_OFS_LINE_DIR) ##1 ce |=> port_oe == $past(pwdata[7:0], 2))
    else $error("output enables do not follow direction write");

  a_masked_quiet: assert property ((ce && !(|req)) |=> irq_n)
    else $error("request raised with nothing to request");

endmodule // gei_top

// ---- verification/gei_host_model.sv ----
// host side model: raises acknowledge cycles and captures the vector answer
// assumes the bench requests a cycle on go and lowers go once done is seen
`timescale 1ns/1ps

module gei_host_model (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic       vector_valid,
  input  wire logic       ack_pass,
  input  wire logic [7:0] vector_num,
  input  wire logic [3:0] hold,
  output logic            ack_cycle_n,
  output logic            done,
  output logic            answered,
  output logic      [7:0] got_num,
  output logic            passed
);
  int n;

  // ----------------------------------------------------------------------
  // acknowledge cycle
  // ----------------------------------------------------------------------
  // handler keeps no mask of its own, so nested requests are acked at once
  initial begin
    ack_cycle_n = 1'b1;
    done        = 1'b0;
    answered    = 1'b0;
    got_num     = 8'h00;
    passed      = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go === 1'b1) begin
        ack_cycle_n <= 1'b0;
        n = 0;
        // a polled device never answers, so give up after a few cycles
        do begin
          @(posedge sys_clk);
          n++;
        end while (vector_valid !== 1'b1 && ack_pass !== 1'b1 && n < 8);
        answered <= vector_valid;
        got_num  <= vector_num;
        passed   <= ack_pass;
        repeat (hold) @(posedge sys_clk);
        ack_cycle_n <= 1'b1;
        done        <= 1'b1;
        @(posedge sys_clk);
        done <= 1'b0;
      end
    end
  end
endmodule // gei_host_model

// ---- verification/gei_testbench.sv ----
// self-checking bench for the interrupt nesting and port block
// assumes gei_top with eight lines, an apb master task and the host model
`timescale 1ns/1ps
`include "gei_params.svh"

module testbench;
  import gei_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [7:0]  port_in = 8'h3C;
  logic [7:0]  port_out;
  logic [7:0]  port_oe;
  logic [7:0]  src_event = 8'h00;
  logic        ack_cycle_n;
  logic        irq_n;
  logic        vector_valid;
  logic [7:0]  vector_num;
  logic        ack_pass;
  logic        go = 1'b0;
  logic [3:0]  hold = 4'h0;
  logic        done;
  logic        answered;
  logic [7:0]  got_num;
  logic        passed;
  int          n_mismatch = 0;
  int          checked = 0;

  always #20 sys_clk = ~sys_clk;

  gei_top #(.LINES(8)) u_gei_top (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .src_event(src_event), .ack_cycle_n(ack_cycle_n), .irq_n(irq_n),
    .vector_valid(vector_valid), .vector_num(vector_num), .ack_pass(ack_pass));

  gei_host_model u_gei_host_model (
    .sys_clk(sys_clk), .go(go), .vector_valid(vector_valid), .ack_pass(ack_pass),
    .vector_num(vector_num), .hold(hold), .ack_cycle_n(ack_cycle_n), .done(done),
    .answered(answered), .got_num(got_num), .passed(passed));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d checked %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, {24'h0, exp});
  endtask

  // pins settle through the synchroniser well within eight cycles
  task automatic pin(input logic [7:0] v);
    @(posedge sys_clk);
    port_in <= v;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic src(input logic [7:0] v);
    @(posedge sys_clk);
    src_event <= v;
    @(posedge sys_clk);
    src_event <= 8'h00;
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_n !== lvl && n < 16) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, irq_n}, {31'h0, lvl});
    if (irq_n !== lvl) end_sim();
  endtask

  task automatic ack(input logic [8:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    go <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 32);
    go <= 1'b0;
    chk({23'h0, answered, got_num}, {23'h0, exp});
    if (done !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`GEI_OFS_IN_SERVICE_A, 8'h00);
    rd(`GEI_OFS_IN_SERVICE_B, 8'h00);
    rd(`GEI_OFS_EDGE_SELECT, 8'h00);
    rd(`GEI_OFS_LINE_DIR, 8'h00);
    chk({24'h0, port_oe}, 32'h0000_0000);
    rd(8'h40, 8'h00);
    chk({31'h0, last_err}, 32'h0000_0001);
    // mixed directions: outputs read back the register, inputs the pins
    wr(`GEI_OFS_LINE_DIR, 8'hF0);
    wr(`GEI_OFS_PORT_DATA, 8'hA5);
    // pins are registered one cycle after the write lands
    repeat (2) @(posedge sys_clk);
    chk({24'h0, port_oe}, 32'h0000_00F0);
    chk({24'h0, port_out}, 32'h0000_00A5);
    rd(`GEI_OFS_PORT_DATA, 8'hAC);
    wr(`GEI_OFS_LINE_DIR, 8'h00);
    // edge chosen before the channel is enabled, so no spurious event
    wr(`GEI_OFS_EDGE_SELECT, 8'h01);
    pin(8'h00);
    wr(`GEI_OFS_ENABLE_B, 8'h11);
    wr(`GEI_OFS_MASK_B, 8'h11);
    pin(8'h01);
    wait_irq(1'b0);
    rd(`GEI_OFS_PENDING_B, 8'h01);
    wr(`GEI_OFS_PENDING_B, 8'hFF);
    rd(`GEI_OFS_PENDING_B, 8'h01);
    wr(`GEI_OFS_PENDING_B, 8'hFE);
    pin(8'h00);
    rd(`GEI_OFS_PENDING_B, 8'h00);
    // clearing the edge bit under a low line is itself a qualifying transition
    wr(`GEI_OFS_EDGE_SELECT, 8'h00);
    rd(`GEI_OFS_PENDING_B, 8'h01);
    wr(`GEI_OFS_EDGE_SELECT, 8'h01);
    wr(`GEI_OFS_PENDING_B, 8'hFE);
    // automatic end mode
    wr(`GEI_OFS_VECTOR, 8'h40);
    pin(8'h01);
    wait_irq(1'b0);
    ack(9'h140);
    rd(`GEI_OFS_PENDING_B, 8'h00);
    rd(`GEI_OFS_IN_SERVICE_B, 8'h00);
    src(8'h01);
    wait_irq(1'b0);
    ack(9'h144);
    // nothing left to request: the acknowledge is passed on
    ack(9'h040);
    chk({31'h0, passed}, 32'h0000_0001);
    // software end mode with a slow host
    hold <= 4'h3;
    wr(`GEI_OFS_VECTOR, 8'h48);
    pin(8'h00);
    pin(8'h01);
    wait_irq(1'b0);
    ack(9'h140);
    rd(`GEI_OFS_IN_SERVICE_B, 8'h01);
    pin(8'h00);
    pin(8'h01);
    rd(`GEI_OFS_PENDING_B, 8'h01);
    chk({31'h0, irq_n}, 32'h0000_0001);
    src(8'h01);
    wait_irq(1'b0);
    ack(9'h144);
    rd(`GEI_OFS_IN_SERVICE_B, 8'h11);
    wr(`GEI_OFS_IN_SERVICE_B, 8'hEF);
    rd(`GEI_OFS_IN_SERVICE_B, 8'h01);
    chk({31'h0, irq_n}, 32'h0000_0001);
    wr(`GEI_OFS_IN_SERVICE_B, 8'hFE);
    wait_irq(1'b0);
    ack(9'h140);
    wr(`GEI_OFS_IN_SERVICE_B, 8'hFE);
    // masked channel still pends
    hold <= 4'h0;
    wr(`GEI_OFS_VECTOR, 8'h40);
    wr(`GEI_OFS_MASK_B, 8'h10);
    pin(8'h00);
    pin(8'h01);
    rd(`GEI_OFS_PENDING_B, 8'h01);
    chk({31'h0, irq_n}, 32'h0000_0001);
    wr(`GEI_OFS_MASK_B, 8'h11);
    wait_irq(1'b0);
    // polled operation ignores the acknowledge
    wr(`GEI_OFS_CONTROL, 8'h01);
    ack(9'h040);
    chk({31'h0, passed}, 32'h0000_0000);
    rd(`GEI_OFS_PENDING_B, 8'h01);
    end_sim();
  end
endmodule // testbench
